// ==== verilog/xpe_exec.v ====
`include "xpe_defines.vh"
// Function
// - Extended instructions act only while the extended set enable bit is set.
// - Pointer add sums the unsigned six-bit literal into the selected pointer.
// - Literal 0 to 63; select 0, 1 or 2 names one of three pointers.
// - None of these four instructions changes any status flag.
// - Select value 3 is add-and-return, always on the stack frame pointer.
// - Add-and-return adds literal to frame pointer then loads counter from stack top.
// - Add-and-return takes two cycles; pointer written first Q4, second cycle idle.
// - Opcode 0014h with no operands is the register indirect call.
// - Register call first pushes counter plus two onto the return stack.
// - Then working register to low byte, latches to high and upper bytes.
// - Register call takes two cycles; second is idle while target is fetched.
// - Register call makes no shadow save of working, status or bank registers.
// - Indexed move: first word 1110 1011 0 plus offset, second word 1111 plus address.
// - Source is frame pointer plus 0..127 offset, copied to absolute 0..4095.
// - Destination comes from the twelve-bit literal of the second word.
// - An indirect register as source returns 00h instead of indirect access.
module xpe_exec
(
   // Clock and reset
   input wire SYS_CLK_IN,
   input wire RST_IN,
   // Core context
   input wire EXT_ENABLE_IN,
   input wire [3:0] QPHASE_IN,
   input wire [15:0] INSTR_IN,
   input wire INSTR_VALID_IN,
   input wire [20:0] PC_IN,
   input wire [7:0] WORKING_REGISTER_IN,
   input wire [7:0] COUNTER_HIGH_LATCH_IN,
   input wire [7:0] COUNTER_UPPER_LATCH_IN,
   input wire [20:0] STACK_TOP_IN,
   // Data memory read
   output wire [11:0] RD_ADDR_OUT,
   output wire RD_EN_OUT,
   input wire [7:0] RD_DATA_IN,
   input wire RD_INDIRECT_IN,
   // Data memory write
   output reg [11:0] WR_ADDR_OUT,
   output reg [7:0] WR_DATA_OUT,
   output reg WR_EN_OUT,
   // Program counter and stack
   output reg [20:0] PC_LOAD_OUT,
   output reg PC_LOAD_EN_OUT,
   output reg [20:0] PUSH_DATA_OUT,
   output reg PUSH_EN_OUT,
   output reg POP_EN_OUT,
   // Pipeline
   output wire FORCE_NOP_OUT,
   output wire CONSUME_SECOND_OUT,
   output wire BUSY_OUT,
   // Pointers
   output wire [11:0] PTR0_OUT,
   output wire [11:0] PTR1_OUT,
   output wire [11:0] PTR2_OUT
);
   localparam ST_IDLE = 4'h1;
   localparam ST_RET = 4'h2;
   localparam ST_CALL = 4'h4;
   localparam ST_MOVE = 4'h8;

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [11:0] ptr0_reg;
   reg [11:0] ptr1_reg;
   reg [11:0] ptr2_reg;
   reg [11:0] src_addr_reg;
   reg [7:0] src_data_reg;
   reg [5:0] lit_reg;
   reg [1:0] sel_reg;

   wire is_ptr_add;
   wire is_ptr_ret;
   wire is_call;
   wire is_move;
   wire idle;
   wire q1;
   wire q4;

   function [11:0] add_ptr;
      input [11:0] base;
      input [6:0] ofs;
      begin
         add_ptr = base + {5'h00, ofs};
      end
   endfunction

   xpe_decode xpe_decode_inst
   (
      .word_in(INSTR_IN),
      .enable_in(EXT_ENABLE_IN && INSTR_VALID_IN),
      .is_ptr_add_out(is_ptr_add),
      .is_ptr_ret_out(is_ptr_ret),
      .is_call_out(is_call),
      .is_move_out(is_move)
   );

   assign idle = (state_reg == ST_IDLE);
   assign q1 = (QPHASE_IN == `XPE_Q1);
   assign q4 = (QPHASE_IN == `XPE_Q4);
   // Second cycle of every two-cycle instruction is a no-operation
   assign FORCE_NOP_OUT = !idle;
   assign CONSUME_SECOND_OUT = (state_reg == ST_MOVE);
   assign BUSY_OUT = !idle;
   assign PTR0_OUT = ptr0_reg;
   assign PTR1_OUT = ptr1_reg;
   assign PTR2_OUT = ptr2_reg;
   // Source address loaded in Q1 to Q3 so the read in Q4 sees a stable address
   assign RD_ADDR_OUT = src_addr_reg;
   assign RD_EN_OUT = idle && is_move && q4;

   always @*
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (q4 && is_ptr_ret)
               state_next = ST_RET;
            else if (q4 && is_call)
               state_next = ST_CALL;
            else if (q4 && is_move)
               state_next = ST_MOVE;
         end
         ST_RET, ST_CALL, ST_MOVE:
         begin
            if (q4)
               state_next = ST_IDLE;
         end
         default:
         begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // No status, working or bank register is touched by any path here
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
      begin
         state_reg <= ST_IDLE;
         ptr0_reg <= `XPE_PTR_RESET;
         ptr1_reg <= `XPE_PTR_RESET;
         ptr2_reg <= `XPE_PTR_RESET;
         src_addr_reg <= 12'h000;
         src_data_reg <= 8'h00;
         lit_reg <= 6'h00;
         sel_reg <= 2'h0;
         WR_ADDR_OUT <= 12'h000;
         WR_DATA_OUT <= 8'h00;
         WR_EN_OUT <= 1'b0;
         PC_LOAD_OUT <= 21'h00_0000;
         PC_LOAD_EN_OUT <= 1'b0;
         PUSH_DATA_OUT <= 21'h00_0000;
         PUSH_EN_OUT <= 1'b0;
         POP_EN_OUT <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         WR_EN_OUT <= 1'b0;
         PC_LOAD_EN_OUT <= 1'b0;
         PUSH_EN_OUT <= 1'b0;
         POP_EN_OUT <= 1'b0;
         if (idle && q1)
         begin
            lit_reg <= INSTR_IN[`XPE_LIT6_MSB:0];
            sel_reg <= INSTR_IN[`XPE_SEL_MSB:`XPE_SEL_LSB];
         end
         if (idle && is_move && !q4)
            src_addr_reg <= add_ptr(ptr2_reg, INSTR_IN[`XPE_OFS7_MSB:0]);
         if (idle && q4)
         begin
            // Literal and select were captured in Q1, so the sum uses the latched copy
            if (is_ptr_add)
            begin
               case (sel_reg)
                  2'h0: ptr0_reg <= add_ptr(ptr0_reg, {1'b0, lit_reg});
                  2'h1: ptr1_reg <= add_ptr(ptr1_reg, {1'b0, lit_reg});
                  default: ptr2_reg <= add_ptr(ptr2_reg, {1'b0, lit_reg});
               endcase
            end
            if (is_ptr_ret)
            begin
               ptr2_reg <= add_ptr(ptr2_reg, {1'b0, lit_reg});
               PC_LOAD_OUT <= STACK_TOP_IN;
               PC_LOAD_EN_OUT <= 1'b1;
               POP_EN_OUT <= 1'b1;
            end
            if (is_call)
            begin
               PUSH_DATA_OUT <= PC_IN + `XPE_RET_STEP;
               PUSH_EN_OUT <= 1'b1;
               PC_LOAD_OUT <= {COUNTER_UPPER_LATCH_IN[4:0], COUNTER_HIGH_LATCH_IN, WORKING_REGISTER_IN};
               PC_LOAD_EN_OUT <= 1'b1;
            end
            if (is_move)
               src_data_reg <= RD_INDIRECT_IN ? `XPE_INDIRECT_VALUE : RD_DATA_IN;
         end
         // Second word supplies destination; no read happens in this cycle
         if ((state_reg == ST_MOVE) && q4 && (INSTR_IN[15:12] == `XPE_OP_SECOND_WORD))
         begin
            WR_ADDR_OUT <= INSTR_IN[`XPE_DST_MSB:0];
            WR_DATA_OUT <= src_data_reg;
            WR_EN_OUT <= 1'b1; // destination range trusted to software
         end
      end
   end
endmodule

// ==== verilog/xpe_defines.vh ====
`ifndef XPE_DEFINES_VH
`define XPE_DEFINES_VH
// Quarter phase one-hot codes
`define XPE_Q1 4'h1
`define XPE_Q2 4'h2
`define XPE_Q3 4'h4
`define XPE_Q4 4'h8
// Opcode patterns
`define XPE_OP_PTR_ADD_HI 8'hE8
`define XPE_OP_MOVE_HI_MSB 9'h1D6
`define XPE_OP_CALL_REG 16'h0014
`define XPE_OP_SECOND_WORD 4'hF
// Field positions
`define XPE_LIT6_MSB 5
`define XPE_SEL_MSB 7
`define XPE_SEL_LSB 6
`define XPE_OFS7_MSB 6
`define XPE_DST_MSB 11
`define XPE_SEL_RETURN 2'h3
`define XPE_SEL_FRAME 2'h2
// Return address step
`define XPE_RET_STEP 21'h00_0002
// Source value when an indirect register is named
`define XPE_INDIRECT_VALUE 8'h00
// Reset values
`define XPE_PTR_RESET 12'h000
`endif

// ==== verilog/xpe_decode.v ====
`include "xpe_defines.vh"
module xpe_decode
(
   // Instruction word and enable
   input wire [15:0] word_in,
   input wire enable_in,
   // Decoded kinds
   output wire is_ptr_add_out,
   output wire is_ptr_ret_out,
   output wire is_call_out,
   output wire is_move_out
);
   wire ptr_form;
   assign ptr_form = enable_in && (word_in[15:8] == `XPE_OP_PTR_ADD_HI);
   assign is_ptr_add_out = ptr_form && (word_in[`XPE_SEL_MSB:`XPE_SEL_LSB] != `XPE_SEL_RETURN);
   assign is_ptr_ret_out = ptr_form && (word_in[`XPE_SEL_MSB:`XPE_SEL_LSB] == `XPE_SEL_RETURN);
   assign is_call_out = enable_in && (word_in == `XPE_OP_CALL_REG);
   assign is_move_out = enable_in && (word_in[15:7] == `XPE_OP_MOVE_HI_MSB);
endmodule

// ==== bench/xpe_exec_checker.sv ====
module xpe_exec_checker (
   // Clock, reset and core context
   input wire logic SYS_CLK_IN, RST_IN, EXT_ENABLE_IN, INSTR_VALID_IN, RD_INDIRECT_IN,
   input wire logic [3:0] QPHASE_IN,
   input wire logic [15:0] INSTR_IN,
   input wire logic [20:0] PC_IN, STACK_TOP_IN,
   input wire logic [7:0] RD_DATA_IN,
   // Design outputs
   input wire logic RD_EN_OUT, WR_EN_OUT, PC_LOAD_EN_OUT, PUSH_EN_OUT, POP_EN_OUT, BUSY_OUT,
   input wire logic [11:0] RD_ADDR_OUT, WR_ADDR_OUT, PTR0_OUT, PTR2_OUT,
   input wire logic [7:0] WR_DATA_OUT,
   input wire logic [20:0] PC_LOAD_OUT, PUSH_DATA_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (RST_IN);
   // Busy is low in the first cycle of every instruction, so it gates decode
   wire logic go = QPHASE_IN == 4'h8 && INSTR_VALID_IN && EXT_ENABLE_IN && !BUSY_OUT;
   wire logic add = go && INSTR_IN[15:8] == 8'hE8;
   wire logic ret = add && INSTR_IN[7:6] == 2'h3;
   wire logic call = go && INSTR_IN == 16'h0014;
   sequence s_hold_nop;
      BUSY_OUT [*4] ##1 !BUSY_OUT;
   endsequence
   sequence s_frame_sum;
      PTR2_OUT == $past(PTR2_OUT) + $past(INSTR_IN[5:0]);
   endsequence
   a_call_push: assert property (call |=> PUSH_EN_OUT && PUSH_DATA_OUT == $past(PC_IN) + 21'h00_0002)
      else $error("call push wrong");
   a_call_hold: assert property (call |=> s_hold_nop)
      else $error("call busy length wrong");
   a_ret_hold: assert property (ret |=> s_hold_nop)
      else $error("return busy length wrong");
   a_ret_load: assert property (ret |=> s_frame_sum and (POP_EN_OUT && PC_LOAD_EN_OUT &&
      PC_LOAD_OUT == $past(STACK_TOP_IN)))
      else $error("return load wrong");
   a_add_ptr0: assert property (add && INSTR_IN[7:6] == 2'h0 |=>
      PTR0_OUT == $past(PTR0_OUT) + $past(INSTR_IN[5:0]) && !BUSY_OUT)
      else $error("pointer add wrong");
   a_off_quiet: assert property (QPHASE_IN == 4'h8 && !EXT_ENABLE_IN && !BUSY_OUT |=>
      $stable(PTR0_OUT) && !PUSH_EN_OUT && !PC_LOAD_EN_OUT)
      else $error("acted while disabled");
   a_move_src: assert property (RD_EN_OUT |-> RD_ADDR_OUT == PTR2_OUT + INSTR_IN[6:0])
      else $error("source address wrong");
   a_move_dst: assert property (WR_EN_OUT |-> WR_ADDR_OUT == $past(INSTR_IN[11:0]) &&
      WR_DATA_OUT == ($past(RD_INDIRECT_IN, 5) ? 8'h00 : $past(RD_DATA_IN, 5)))
      else $error("move write wrong");
endmodule

// ==== bench/xpe_exec_test.sv ====
module xpe_exec_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic SYS_CLK_IN, RST_IN, EXT_ENABLE_IN, INSTR_VALID_IN, RD_INDIRECT_IN, RD_EN_OUT, WR_EN_OUT;
   logic PC_LOAD_EN_OUT, PUSH_EN_OUT, POP_EN_OUT, FORCE_NOP_OUT, CONSUME_SECOND_OUT, BUSY_OUT;
   logic [3:0] QPHASE_IN;
   logic [7:0] WORKING_REGISTER_IN, COUNTER_HIGH_LATCH_IN, COUNTER_UPPER_LATCH_IN, RD_DATA_IN, WR_DATA_OUT;
   logic [11:0] RD_ADDR_OUT, WR_ADDR_OUT, PTR0_OUT, PTR1_OUT, PTR2_OUT;
   logic [15:0] INSTR_IN;
   logic [20:0] PC_IN, STACK_TOP_IN, PC_LOAD_OUT, PUSH_DATA_OUT;
   logic [11:0] ptr_exp [3];
   int errors = 0;
   int checked = 0;
   xpe_exec xpe_exec_inst (.*);
   initial
   begin
      SYS_CLK_IN = 0;
      forever #20 SYS_CLK_IN = ~SYS_CLK_IN;
   end
   // Phases park on Q4 in reset so the first Q1 follows release
   always @(posedge SYS_CLK_IN)
      QPHASE_IN <= RST_IN ? 4'h8 : {QPHASE_IN[2:0], QPHASE_IN[3]};
   function automatic bit differ(input logic [20:0] got, input logic [20:0] want);
      checked++;
      return got !== want;
   endfunction
   task automatic bad(input string msg);
      errors++;
      $display("BAD t=%0t %s", $time, msg);
   endtask
   task automatic print_verdict;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Waits for a Q4, then presents the word from the next Q1 on
   task automatic put(input logic [15:0] w);
      int n;
      n = 0;
      do
      begin
         @(negedge SYS_CLK_IN);
         n++;
      end
      while (QPHASE_IN !== 4'h8 && n < 8);
      if (QPHASE_IN !== 4'h8)
      begin
         bad("no Q4 seen");
         print_verdict;
      end
      @(posedge SYS_CLK_IN);
      INSTR_IN <= w;
   endtask
   task automatic t_add;
      logic [11:0] got;
      if (differ(PTR2_OUT, 0)) bad("pointer reset");
      for (int s = 0; s < 3; s++)
      begin
         put({8'hE8, s[1:0], 6'h3F});
         put(16'h0000);
         @(negedge SYS_CLK_IN);
         ptr_exp[s] = ptr_exp[s] + 12'h03F;
         got = s == 0 ? PTR0_OUT : s == 1 ? PTR1_OUT : PTR2_OUT;
         if (differ(got, ptr_exp[s])) bad("pointer sum");
         if (differ(BUSY_OUT, 0)) bad("add busy");
      end
   endtask
   task automatic t_ret;
      put(16'hE8E3);
      put(16'h0000);
      @(negedge SYS_CLK_IN);
      ptr_exp[2] = ptr_exp[2] + 12'h023;
      if (differ(PTR2_OUT, ptr_exp[2])) bad("frame sum");
      if (differ({POP_EN_OUT, PC_LOAD_EN_OUT, PC_LOAD_OUT}, {2'b11, 21'h0A_BCDE})) bad("return");
      if (differ(BUSY_OUT, 1)) bad("return busy");
   endtask
   task automatic t_call;
      put(16'h0014);
      put(16'h0000);
      @(negedge SYS_CLK_IN);
      if (differ({PUSH_EN_OUT, PUSH_DATA_OUT}, {1'b1, 21'h00_1236})) bad("push");
      if (differ({PC_LOAD_EN_OUT, PC_LOAD_OUT}, {1'b1, 21'h01_1006})) bad("target");
      if (differ(BUSY_OUT, 1)) bad("call busy");
   endtask
   task automatic t_move(input logic ind);
      put(16'hEB7F);
      RD_INDIRECT_IN <= ind;
      put(16'hFFFF);
      put(16'h0000);
      @(negedge SYS_CLK_IN);
      if (differ({WR_EN_OUT, WR_ADDR_OUT}, {1'b1, 12'hFFF})) bad("move dest");
      if (differ(WR_DATA_OUT, ind ? 8'h00 : 8'h33)) bad("move data");
   endtask
   task automatic t_off;
      put(16'h0014);
      EXT_ENABLE_IN <= 0;
      put(16'h0000);
      @(negedge SYS_CLK_IN);
      if (differ({PUSH_EN_OUT, BUSY_OUT, PTR0_OUT}, {2'b00, ptr_exp[0]})) bad("ran while off");
   endtask
   initial
   begin
      QPHASE_IN = 4'h8;
      RST_IN = 1;
      EXT_ENABLE_IN = 1;
      INSTR_VALID_IN = 1;
      INSTR_IN = 16'h0000;
      PC_IN = 21'h00_1234;
      WORKING_REGISTER_IN = 8'h06;
      COUNTER_HIGH_LATCH_IN = 8'h10;
      COUNTER_UPPER_LATCH_IN = 8'h01;
      STACK_TOP_IN = 21'h0A_BCDE;
      RD_DATA_IN = 8'h33;
      RD_INDIRECT_IN = 0;
      ptr_exp = '{default: 12'h000};
      repeat (12) @(posedge SYS_CLK_IN);
      RST_IN <= 0;
      t_add;
      t_ret;
      t_call;
      t_move(0);
      t_move(1);
      t_off;
      print_verdict;
   end
endmodule
bind xpe_exec xpe_exec_checker xpe_exec_checker_inst (.*);
